// File: design/tcm_monitor.sv
// Track completeness monitor: teach run and hysteresis evaluation of hit counts.
// Assumes one profile per FRAME_VALID pulse with its live hit count; points
// arrive as POINT_VALID with a depth in mm during a teach run.
// How it works
// - Completeness output high when objects complete
// - Overcount output high when too many objects
// - Histogram of depths gives top; sensitivity sets minimum
// - Window depth is top plus/minus offset
// - Lateral limits fixed at -300 and +300 mm
// - Network teach returns error number in response
// - Track width is teach hits over count
// - Complete on above taught minus 0.4 width
// - Complete off below taught minus 0.6 width
// - Overcount on above taught plus 0.6 width
// - Overcount off below taught plus 0.4 width
// - Only first two windows; others inactive
// - Sensitivity picks 10/6, 20/12, 40/24; medium default
`timescale 1ns/1ps
module tcm_monitor
	import tcm_pkg::*;
#(
	parameter int HIST_W = 16
) (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic TEACH_START,
	input wire logic TEACH_FROM_NET,
	input wire logic [tcm_pkg::OBJ_W-1:0] EXPECTED_OBJECT_COUNT,
	input wire logic [1:0] SENSITIVITY,
	input wire logic [tcm_pkg::Z_W-1:0] OFFSET_MM,
	input wire logic POINT_VALID,
	input wire logic [tcm_pkg::Z_W-1:0] POINT_Z_MM,
	input wire logic FRAME_VALID,
	input wire logic [tcm_pkg::CNT_W-1:0] LIVE_HIT_COUNT,
	output logic COMPLETENESS_OUTPUT,
	output logic OVERCOUNT_OUTPUT,
	output logic [15:0] ANALYSIS_WINDOW_ACTIVE,
	output logic [15:0] SWITCH_OUTPUT_ACTIVE,
	output logic DETECT_MODE,
	output logic TEACH_BUSY,
	output logic TEACH_DONE,
	output logic [tcm_pkg::ERR_W-1:0] TEACH_ERROR,
	output logic NET_RESPONSE_VALID,
	output logic [tcm_pkg::ERR_W-1:0] NET_RESPONSE_ERROR,
	output logic [tcm_pkg::Z_W-1:0] AW_Z_MAX_MM,
	output logic [tcm_pkg::Z_W-1:0] AW_Z_MIN_MM,
	output logic signed [tcm_pkg::Z_W-1:0] AW_X_MIN_MM,
	output logic signed [tcm_pkg::Z_W-1:0] AW_X_MAX_MM,
	output logic [tcm_pkg::CNT_W-1:0] TAUGHT_HITS,
	output logic [tcm_pkg::CNT_W-1:0] TRACK_WIDTH
);
	import tcm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Fraction of a track width in tenths, floor
	function automatic logic [CNT_W-1:0] frac_of(input logic [CNT_W-1:0] w,
			input logic [3:0] tenths);
		logic [CNT_W+3:0] p;
		p = w * tenths;
		return CNT_W'(p / FRAC_DEN);
	endfunction : frac_of

	// Minimum accepted teach hit count per sensitivity
	function automatic logic [CNT_W-1:0] sens_on(input logic [1:0] s);
		case (s)
			SENS_SMALL: return HITS_ON_SMALL;
			SENS_LARGE: return HITS_ON_LARGE;
			default: return HITS_ON_MEDIUM;
		endcase
	endfunction : sens_on

	////////////////////////////////////////////////////////////////////////
	// Teach sequencer state

	tcm_state_e state_q;
	logic [HIST_W-1:0] hist_q [HBINS];
	logic [HBIN_W-1:0] bin_idx_q;
	logic [HBIN_W-1:0] best_bin_q;
	logic [HIST_W-1:0] best_cnt_q;
	logic [CNT_W-1:0] hit_cnt_q;
	logic [CNT_W-1:0] taught_q;
	logic [CNT_W-1:0] width_q;
	logic [CNT_W-1:0] rem_q;
	logic [CNT_W-1:0] quo_q;
	logic [OBJ_W-1:0] objs_q;
	logic [1:0] sens_q;
	logic net_q;
	logic [ERR_W-1:0] err_q;
	logic [Z_W-1:0] top_q;
	logic [HBIN_W-1:0] pt_bin;
	logic [CNT_W-1:0] thr_c_on, thr_c_off, thr_o_on, thr_o_off;

	assign pt_bin = HBIN_W'(POINT_Z_MM >> HBIN_SHIFT);

	// Main teach sequence: clear, collect one profile, scan, divide
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= TCM_IDLE;
			bin_idx_q <= '0;
			best_bin_q <= '0;
			best_cnt_q <= '0;
			hit_cnt_q <= '0;
			rem_q <= '0;
			quo_q <= '0;
			objs_q <= '0;
			sens_q <= SENS_MEDIUM;
			net_q <= 1'b0;
		end else begin
			case (state_q)
				TCM_IDLE: begin
					if (TEACH_START) begin
						objs_q <= EXPECTED_OBJECT_COUNT;
						sens_q <= SENSITIVITY;
						net_q <= TEACH_FROM_NET;
						bin_idx_q <= '0;
						state_q <= TCM_CLEAR;
					end
				end
				TCM_CLEAR: begin
					bin_idx_q <= bin_idx_q + 1'b1;
					if (bin_idx_q == HBIN_W'(HBINS - 1)) begin
						hit_cnt_q <= '0;
						state_q <= TCM_COLLECT;
					end
				end
				TCM_COLLECT: begin
					if (POINT_VALID) begin
						hit_cnt_q <= hit_cnt_q + 1'b1;
					end
					if (FRAME_VALID) begin
						bin_idx_q <= '0;
						best_cnt_q <= '0;
						best_bin_q <= '0;
						state_q <= TCM_SCAN;
					end
				end
				TCM_SCAN: begin
					// Dominant bin becomes the object top
					if (hist_q[bin_idx_q] > best_cnt_q) begin
						best_cnt_q <= hist_q[bin_idx_q];
						best_bin_q <= bin_idx_q;
					end
					bin_idx_q <= bin_idx_q + 1'b1;
					if (bin_idx_q == HBIN_W'(HBINS - 1)) begin
						rem_q <= hit_cnt_q;
						quo_q <= '0;
						state_q <= TCM_DIVIDE;
					end
				end
				TCM_DIVIDE: begin
					// Repeated subtraction for hits / objects
					if (objs_q != '0 && rem_q >= CNT_W'(objs_q)) begin
						rem_q <= rem_q - CNT_W'(objs_q);
						quo_q <= quo_q + 1'b1;
					end else begin
						state_q <= TCM_DONE;
					end
				end
				default: state_q <= TCM_IDLE;
			endcase
		end
	end

	// Histogram bins
	always_ff @(posedge CLOCK) begin
		if (state_q == TCM_CLEAR) begin
			hist_q[bin_idx_q] <= '0;
		end else if (state_q == TCM_COLLECT && POINT_VALID) begin
			hist_q[pt_bin] <= hist_q[pt_bin] + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Teach results and window

	// Outcome check and storing of the taught window
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			err_q <= ERR_OK;
			taught_q <= '0;
			width_q <= '0;
			top_q <= '0;
			AW_Z_MAX_MM <= '0;
			AW_Z_MIN_MM <= '0;
			DETECT_MODE <= 1'b0;
			TEACH_DONE <= 1'b0;
			NET_RESPONSE_VALID <= 1'b0;
			NET_RESPONSE_ERROR <= ERR_OK;
		end else begin
			TEACH_DONE <= 1'b0;
			NET_RESPONSE_VALID <= 1'b0;
			if (state_q == TCM_IDLE && TEACH_START) begin
				DETECT_MODE <= 1'b0;
			end
			if (state_q == TCM_DONE) begin
				TEACH_DONE <= 1'b1;
				NET_RESPONSE_VALID <= net_q;
				if (objs_q == '0) begin
					err_q <= ERR_NO_OBJECTS;
					NET_RESPONSE_ERROR <= ERR_NO_OBJECTS;
				end else if (hit_cnt_q < sens_on(sens_q)) begin
					err_q <= ERR_FEW_HITS;
					NET_RESPONSE_ERROR <= ERR_FEW_HITS;
				end else if (best_cnt_q == '0) begin
					err_q <= ERR_NO_TOP;
					NET_RESPONSE_ERROR <= ERR_NO_TOP;
				end else begin
					err_q <= ERR_OK;
					NET_RESPONSE_ERROR <= ERR_OK;
					taught_q <= hit_cnt_q;
					width_q <= quo_q;
					top_q <= Z_W'({best_bin_q, {HBIN_SHIFT{1'b0}}});
					AW_Z_MAX_MM <= Z_W'({best_bin_q, {HBIN_SHIFT{1'b0}}}) + OFFSET_MM;
					AW_Z_MIN_MM <= Z_W'({best_bin_q, {HBIN_SHIFT{1'b0}}}) - OFFSET_MM;
					DETECT_MODE <= 1'b1;
				end
			end
		end
	end

	// Fixed lateral limits and window/output masks
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			AW_X_MIN_MM <= X_MIN_MM;
			AW_X_MAX_MM <= X_MAX_MM;
			ANALYSIS_WINDOW_ACTIVE <= '0;
			SWITCH_OUTPUT_ACTIVE <= '0;
		end else begin
			AW_X_MIN_MM <= X_MIN_MM;
			AW_X_MAX_MM <= X_MAX_MM;
			ANALYSIS_WINDOW_ACTIVE <= DETECT_MODE ? AW_USED : '0;
			SWITCH_OUTPUT_ACTIVE <= DETECT_MODE ? AW_USED : '0;
		end
	end

	// Status mirrors
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			TEACH_BUSY <= 1'b0;
			TEACH_ERROR <= ERR_OK;
			TAUGHT_HITS <= '0;
			TRACK_WIDTH <= '0;
		end else begin
			TEACH_BUSY <= (state_q != TCM_IDLE);
			TEACH_ERROR <= err_q;
			TAUGHT_HITS <= taught_q;
			TRACK_WIDTH <= width_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Detection with hysteresis

	assign thr_c_on = taught_q - frac_of(width_q, FRAC_NEAR);
	assign thr_c_off = taught_q - frac_of(width_q, FRAC_FAR);
	assign thr_o_on = taught_q + frac_of(width_q, FRAC_FAR);
	assign thr_o_off = taught_q + frac_of(width_q, FRAC_NEAR);

	// Outputs update once per frame in detect mode, otherwise they hold; cleared when not in detect mode
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			COMPLETENESS_OUTPUT <= 1'b0;
			OVERCOUNT_OUTPUT <= 1'b0;
		end else if (!DETECT_MODE) begin
			COMPLETENESS_OUTPUT <= 1'b0;
			OVERCOUNT_OUTPUT <= 1'b0;
		end else if (FRAME_VALID) begin
			if (LIVE_HIT_COUNT > thr_c_on) begin
				COMPLETENESS_OUTPUT <= 1'b1;
			end else if (LIVE_HIT_COUNT < thr_c_off) begin
				COMPLETENESS_OUTPUT <= 1'b0;
			end
			if (LIVE_HIT_COUNT > thr_o_on) begin
				OVERCOUNT_OUTPUT <= 1'b1;
			end else if (LIVE_HIT_COUNT < thr_o_off) begin
				OVERCOUNT_OUTPUT <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	complete_on_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		DETECT_MODE && FRAME_VALID && LIVE_HIT_COUNT > thr_c_on |=> COMPLETENESS_OUTPUT)
		else $error("completeness did not switch on");
	complete_off_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		DETECT_MODE && FRAME_VALID && LIVE_HIT_COUNT < thr_c_off |=> !COMPLETENESS_OUTPUT)
		else $error("completeness did not switch off");
	over_on_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		DETECT_MODE && FRAME_VALID && LIVE_HIT_COUNT > thr_o_on |=> OVERCOUNT_OUTPUT)
		else $error("overcount did not switch on");
	over_off_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		DETECT_MODE && FRAME_VALID && LIVE_HIT_COUNT < thr_o_off |=> !OVERCOUNT_OUTPUT)
		else $error("overcount did not switch off");
	hold_state_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		DETECT_MODE && !FRAME_VALID && $past(DETECT_MODE)
		|=> $stable(COMPLETENESS_OUTPUT) && $stable(OVERCOUNT_OUTPUT))
		else $error("output changed without a frame");
	window_depth_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		$rose(DETECT_MODE) |-> AW_Z_MAX_MM - AW_Z_MIN_MM == Z_W'(OFFSET_MM << 1))
		else $error("window depth span wrong");
	lateral_fixed_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		AW_X_MIN_MM == X_MIN_MM && AW_X_MAX_MM == X_MAX_MM)
		else $error("lateral limits moved");
	mask_two_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		DETECT_MODE |=> ANALYSIS_WINDOW_ACTIVE == AW_USED)
		else $error("window mask wrong");
	net_resp_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		state_q == TCM_DONE && net_q |=> NET_RESPONSE_VALID && NET_RESPONSE_ERROR == err_q)
		else $error("network response missing");
	width_div_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		$rose(DETECT_MODE) |-> taught_q >= width_q * CNT_W'(objs_q)
		&& taught_q - width_q * CNT_W'(objs_q) < CNT_W'(objs_q))
		else $error("track width not a quotient");
	few_hits_a: assert property (@(posedge CLOCK) disable iff (!RSTN)
		state_q == TCM_DONE && objs_q != '0 && hit_cnt_q < sens_on(sens_q)
		|=> !DETECT_MODE && err_q == ERR_FEW_HITS)
		else $error("short teach accepted");

	teach_ok_c: cover property (@(posedge CLOCK) $rose(DETECT_MODE));
	complete_c: cover property (@(posedge CLOCK) $rose(COMPLETENESS_OUTPUT));
	over_c: cover property (@(posedge CLOCK) $rose(OVERCOUNT_OUTPUT));
	net_c: cover property (@(posedge CLOCK) NET_RESPONSE_VALID);
endmodule : tcm_monitor

// File: design/tcm_pkg.sv
// Package for the track completeness monitor: constants and state types.
// Assumes a single 20 MHz clock domain; no registers on a bus.
package tcm_pkg;
	// Clock rate
	localparam int CLK_HZ = 20000000;
	// Widths
	localparam int CNT_W = 16;
	localparam int Z_W = 16;
	localparam int OBJ_W = 8;
	localparam int ERR_W = 4;
	// Histogram
	localparam int HBIN_W = 5;
	localparam int HBINS = 32;
	localparam int HBIN_SHIFT = 5;
	// Sensitivity levels: switch-on and switch-off hit counts
	localparam logic [1:0] SENS_SMALL = 2'h0;
	localparam logic [1:0] SENS_MEDIUM = 2'h1;
	localparam logic [1:0] SENS_LARGE = 2'h2;
	localparam logic [CNT_W-1:0] HITS_ON_SMALL = 16'h000A;
	localparam logic [CNT_W-1:0] HITS_OFF_SMALL = 16'h0006;
	localparam logic [CNT_W-1:0] HITS_ON_MEDIUM = 16'h0014;
	localparam logic [CNT_W-1:0] HITS_OFF_MEDIUM = 16'h000C;
	localparam logic [CNT_W-1:0] HITS_ON_LARGE = 16'h0028;
	localparam logic [CNT_W-1:0] HITS_OFF_LARGE = 16'h0018;
	// Lateral window limits in mm (signed)
	localparam logic signed [Z_W-1:0] X_MIN_MM = -16'sh012C;
	localparam logic signed [Z_W-1:0] X_MAX_MM = 16'sh012C;
	// Threshold factors in tenths of a track width
	localparam logic [3:0] FRAC_NEAR = 4'h4;
	localparam logic [3:0] FRAC_FAR = 4'h6;
	localparam logic [3:0] FRAC_DEN = 4'hA;
	// Teach outcome codes
	localparam logic [ERR_W-1:0] ERR_OK = 4'h0;
	localparam logic [ERR_W-1:0] ERR_FEW_HITS = 4'h1;
	localparam logic [ERR_W-1:0] ERR_NO_OBJECTS = 4'h2;
	localparam logic [ERR_W-1:0] ERR_NO_TOP = 4'h3;
	// Active output pattern: only the first two windows/outputs are used
	localparam logic [15:0] AW_USED = 16'h0003;
	typedef enum logic [2:0] {
		TCM_IDLE = 3'b000,
		TCM_CLEAR = 3'b001,
		TCM_COLLECT = 3'b010,
		TCM_SCAN = 3'b011,
		TCM_DIVIDE = 3'b100,
		TCM_DONE = 3'b101
	} tcm_state_e;
endpackage : tcm_pkg

// File: sim/tcm_ctrl_model.sv
// Process controller model watching the two switching outputs.
// Assumes both outputs are registered in the CLOCK domain.
`timescale 1ns/1ps
module tcm_ctrl_model (
	input wire logic clock,
	input wire logic rstn,
	input wire logic complete_in,
	input wire logic over_in,
	output logic [7:0] rise_count,
	output logic bad_combo
);
	logic prev_q;
	////////////////////////////////////////////////////////////////////////////
	// Count complete rises; flag overcount seen without complete
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prev_q <= 1'b0;
			rise_count <= 8'h00;
			bad_combo <= 1'b0;
		end else begin
			prev_q <= complete_in;
			if (complete_in && !prev_q) begin
				rise_count <= rise_count + 8'h01;
			end
			if (over_in && !complete_in) begin
				bad_combo <= 1'b1;
			end
		end
	end
endmodule : tcm_ctrl_model

// File: sim/tcm_monitor_tb.sv
// Testbench for the track completeness monitor: teach runs and frames.
// Assumes the monitor and its controller model; inputs driven at rising edge.
`timescale 1ns/1ps
module tcm_monitor_tb;
	import tcm_pkg::*;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic teach_start = 1'b0;
	logic teach_net = 1'b0;
	logic [OBJ_W-1:0] obj_cnt = 8'h00;
	logic [1:0] sens = 2'h1;
	logic [Z_W-1:0] offset = 16'h0014;
	logic point_valid = 1'b0;
	logic [Z_W-1:0] point_z = 16'h0000;
	logic frame_valid = 1'b0;
	logic [CNT_W-1:0] live = 16'h0000;
	logic complete, over, detect, busy, done, net_valid, bad;
	logic [15:0] aw_act, sw_act;
	logic [ERR_W-1:0] t_err, n_err;
	logic [Z_W-1:0] z_max, z_min, x_min, x_max, taught, width;
	logic [7:0] rises;
	int lv[10] = '{35, 37, 35, 33, 36, 47, 45, 46, 43, 37};
	logic [1:0] ex[10] = '{2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2};
	int fails = 0;
	int check_count = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////////////////
	// Clock and timeout
	always #25 clock = ~clock;
	always @(posedge clock) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			summarize();
		end
	end
	tcm_monitor i_dut (.CLOCK(clock), .RSTN(rstn), .TEACH_START(teach_start),
		.TEACH_FROM_NET(teach_net), .EXPECTED_OBJECT_COUNT(obj_cnt), .SENSITIVITY(sens),
		.OFFSET_MM(offset), .POINT_VALID(point_valid), .POINT_Z_MM(point_z),
		.FRAME_VALID(frame_valid), .LIVE_HIT_COUNT(live), .COMPLETENESS_OUTPUT(complete),
		.OVERCOUNT_OUTPUT(over), .ANALYSIS_WINDOW_ACTIVE(aw_act),
		.SWITCH_OUTPUT_ACTIVE(sw_act), .DETECT_MODE(detect), .TEACH_BUSY(busy),
		.TEACH_DONE(done), .TEACH_ERROR(t_err), .NET_RESPONSE_VALID(net_valid),
		.NET_RESPONSE_ERROR(n_err), .AW_Z_MAX_MM(z_max), .AW_Z_MIN_MM(z_min),
		.AW_X_MIN_MM(x_min), .AW_X_MAX_MM(x_max), .TAUGHT_HITS(taught),
		.TRACK_WIDTH(width));
	tcm_ctrl_model i_ctrl (.clock(clock), .rstn(rstn), .complete_in(complete),
		.over_in(over), .rise_count(rises), .bad_combo(bad));
	////////////////////////////////////////////////////////////////////////////
	// Compare, frame and teach tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic frame(input logic [CNT_W-1:0] v);
		@(posedge clock);
		frame_valid <= 1'b1;
		live <= v;
		@(posedge clock);
		frame_valid <= 1'b0;
		@(posedge clock);
		#1;
	endtask : frame
	task automatic teach(input logic net, input logic [7:0] cnt, input logic [1:0] s,
		input int npts, input logic [3:0] err);
		int i;
		logic ok;
		logic [Z_W-1:0] top;
		ok = (err == ERR_OK);
		top = (16'h01F4 >> HBIN_SHIFT) << HBIN_SHIFT;
		// Count and sensitivity set together with the start pulse
		@(posedge clock);
		teach_start <= 1'b1;
		teach_net <= net;
		obj_cnt <= cnt;
		sens <= s;
		@(posedge clock);
		teach_start <= 1'b0;
		repeat (5) @(posedge clock);
		teach_start <= 1'b1;
		@(posedge clock);
		teach_start <= 1'b0;
		repeat (35) @(posedge clock);
		for (i = 0; i < npts; i++) begin
			point_valid <= 1'b1;
			point_z <= 16'h01F4;
			@(posedge clock);
		end
		point_valid <= 1'b0;
		frame_valid <= 1'b1;
		@(posedge clock);
		frame_valid <= 1'b0;
		for (i = 0; i < 300 && done !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		check(done, 1'b1);
		check(net_valid, net);
		check(n_err, err);
		check(detect, ok);
		// Status mirrors and masks follow one cycle after the done pulse
		@(posedge clock);
		#1;
		check(t_err, err);
		check(aw_act, ok ? AW_USED : 16'h0000);
		check(sw_act, ok ? AW_USED : 16'h0000);
		check(x_min, X_MIN_MM);
		check(x_max, X_MAX_MM);
		if (ok) begin
			check(taught, 16'(npts));
			check(width, 16'(npts / cnt));
			check(z_max, top + offset);
			check(z_min, top - offset);
		end
	endtask : teach
	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		#1;
		check(x_min, X_MIN_MM);
		check({complete, over}, 2'h0);
		check(aw_act, 16'h0000);
		// Taught 40 hits over 4 tracks: width 10
		teach(1'b1, 8'h04, SENS_MEDIUM, 40, ERR_OK);
		for (int i = 0; i < 10; i++) begin
			frame(16'(lv[i]));
			check(complete, ex[i][1]);
			check(over, ex[i][0]);
		end
		check(rises, 8'h02);
		teach(1'b0, 8'h00, SENS_MEDIUM, 40, ERR_NO_OBJECTS);
		frame(16'h0028);
		check({complete, over}, 2'h0);
		teach(1'b1, 8'h02, SENS_LARGE, 30, ERR_FEW_HITS);
		teach(1'b0, 8'h01, SENS_SMALL, 12, ERR_OK);
		frame(16'h000C);
		check({complete, over}, 2'h2);
		check(bad, 1'b0);
		summarize();
	end
endmodule : tcm_monitor_tb
